// ===== rtl/ecgcfg_top.v
// Status and rate configuration register bank of a three channel
// biopotential front end, with data-ready, sync and alarm pin logic.
// Assumes a plain register port on clk, analog status levels arriving
// asynchronously, and ready pulses from filter logic on clk.
`timescale 1ns/10ps
`include "ecgcfg_regs.vh"

module ecgcfg_top (
  input wire clk,
  input wire rst_n,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Digital clock enable from the clock control register
  input wire clk_digital_en,
  // Raw analog channel three range levels
  input wire modulator_overrange_ch3,
  input wire amp_output_a,
  input wire neg_out_near_low_rail_ch3,
  input wire neg_out_near_high_rail_ch3,
  input wire pos_out_near_low_rail_ch3,
  input wire pos_out_near_high_rail_ch3,
  input wire diff_out_range_ch3,
  // Raw sync error levels
  input wire timing_phase_adjusted,
  input wire filter_timing_resync_ch1,
  input wire filter_timing_resync_ch2,
  input wire filter_timing_resync_ch3,
  // Raw miscellaneous error levels
  input wire low_supply_flag,
  input wire leg_drive_near_rail_flag,
  input wire common_level_out_of_range_flag,
  // Other alarm conditions kept elsewhere
  input wire sync_edge_error,
  input wire range_error_ch1,
  input wire range_error_ch2,
  input wire electrode_off,
  // Filter side, same clock
  input wire [2:0] pace_ready,
  input wire [2:0] ecg_ready,
  input wire [2:0] ecg_channel_en,
  input wire start_conversion_ctl,
  input wire out_of_sync_detect,
  // Configuration outputs
  output wire [1:0] drive_strength,
  output wire [3:0] second_stage_rate,
  output wire [7:0] third_stage_rate_ch1,
  output wire [7:0] third_stage_rate_ch2,
  output wire [7:0] third_stage_rate_ch3,
  output wire [2:0] pace_rate_double,
  output wire [2:0] ecg_filter_bypass,
  // Pins
  output reg data_ready_n_pin,
  output reg sync_pin_o,
  output wire sync_pin_oe,
  input wire sync_pin_i,
  output reg sync_pin_fall,
  output reg alarm_n_pin,
  output wire alarm_status
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  reg [6:0] range3; // Channel three range status
  reg [3:0] sync_err; // Sync error status
  reg [2:0] misc_err; // Misc error status
  reg [1:0] drive; // Drive strength field
  reg [3:0] second_stage_decimation; // Second stage one-hot
  reg [7:0] r3_rate [0:2]; // Third stage one-hot per channel
  reg [2:0] pace_rate; // Pace rate bits
  reg [2:0] bypass; // ECG filter bypass bits
  reg [5:0] dr_src; // Data-ready source
  reg [5:0] sync_src; // Sync pin source
  reg sync_dir; // Sync pin input select
  reg [1:0] dr_mask_ctl; // Data-ready mask disables
  reg [7:0] alarm_mask; // Alarm condition masks
  reg [3:0] mask_count; // Periods left in mask interval
  reg masking; // Mask interval running
  reg start_d; // Delayed start control
  reg sync_in_s1; // Sync pin first stage
  reg sync_in_s2; // Sync pin second stage
  reg sync_in_d; // Sync pin previous level
  reg [17:0] raw_s1; // Status first stage
  reg [17:0] raw_s2; // Status second stage

  // ------------------------------------------------------------
  // One-hot check
  // ------------------------------------------------------------
  function onehot8;
    input [7:0] v;
    begin
      onehot8 = (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
    end
  endfunction

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  wire [17:0] raw_in;
  assign raw_in = {electrode_off, range_error_ch1, range_error_ch2,
    sync_edge_error, low_supply_flag, leg_drive_near_rail_flag,
    common_level_out_of_range_flag, timing_phase_adjusted,
    filter_timing_resync_ch3, filter_timing_resync_ch2,
    filter_timing_resync_ch1, modulator_overrange_ch3, amp_output_a,
    neg_out_near_low_rail_ch3, neg_out_near_high_rail_ch3,
    pos_out_near_low_rail_ch3, pos_out_near_high_rail_ch3,
    diff_out_range_ch3};

  // Two flops on every asynchronous level
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      raw_s1 <= 18'h00000;
      raw_s2 <= 18'h00000;
      sync_in_s1 <= 1'b1;
      sync_in_s2 <= 1'b1;
    end
    else
    begin
      raw_s1 <= raw_in;
      raw_s2 <= raw_s1;
      sync_in_s1 <= sync_pin_i;
      sync_in_s2 <= sync_in_s1;
    end
  end

  // ------------------------------------------------------------
  // Error status capture
  // ------------------------------------------------------------
  // Frozen while the digital clock is off
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      range3 <= 7'h00;
      sync_err <= 4'h0;
      misc_err <= 3'h0;
    end
    else if (clk_digital_en)
    begin
      // Over-range, sign, rails, differential
      range3 <= raw_s2[6:0];
      sync_err <= raw_s2[10:7];
      misc_err <= raw_s2[13:11];
    end
  end

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  wire [7:0] r2_new;
  assign r2_new = {4'h0, reg_wdata[3:0]};

  // Status addresses take no write
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      drive <= `ECGCFG_RST_DRIVE;
      second_stage_decimation <= `ECGCFG_RST_R2;
      pace_rate <= `ECGCFG_RST_PACE;
      bypass <= `ECGCFG_RST_BYPASS;
      dr_src <= `ECGCFG_RST_DRSRC;
      sync_src <= `ECGCFG_RST_SYNCSRC;
      sync_dir <= `ECGCFG_RST_SYNCDIR;
      dr_mask_ctl <= `ECGCFG_RST_DRMASK;
      alarm_mask <= `ECGCFG_RST_ALMASK;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `ECGCFG_ADDR_DRIVE:
          drive <= reg_wdata[1:0];
        `ECGCFG_ADDR_R2:
          // Invalid pattern restores default
          second_stage_decimation <= onehot8(r2_new) ? reg_wdata[3:0]
                                     : `ECGCFG_RST_R2;
        `ECGCFG_ADDR_PACE:
          pace_rate <= reg_wdata[2:0];
        `ECGCFG_ADDR_BYPASS:
          bypass <= reg_wdata[2:0];
        `ECGCFG_ADDR_DRSRC:
          dr_src <= reg_wdata[5:0];
        `ECGCFG_ADDR_SYNCCTL:
        begin
          sync_dir <= reg_wdata[`ECGCFG_SYNCCTL_DIR];
          sync_src <= reg_wdata[5:0];
        end
        `ECGCFG_ADDR_DRMASK:
          dr_mask_ctl <= reg_wdata[1:0];
        `ECGCFG_ADDR_ALMASK:
          alarm_mask <= reg_wdata;
        default:
          // Status and unmapped addresses ignored
          drive <= drive;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Third stage rate per channel
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_r3
      // Each channel validates its own one-hot write
      always @(posedge clk)
      begin
        if (!rst_n)
          r3_rate[gi] <= `ECGCFG_RST_R3;
        else if (reg_wr &&
                 {24'h000000, reg_addr} == `ECGCFG_ADDR_R3CH1 + gi)
          r3_rate[gi] <= onehot8(reg_wdata) ? reg_wdata
                                            : `ECGCFG_RST_R3;
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------
  reg [7:0] next_rdata;

  // Read data selection, reserved bits zero
  always @*
  begin
    case (reg_addr)
      `ECGCFG_ADDR_RANGE3: next_rdata = {1'b0, range3};
      `ECGCFG_ADDR_SYNCERR: next_rdata = {4'h0, sync_err};
      `ECGCFG_ADDR_MISCERR: next_rdata = {5'h00, misc_err};
      `ECGCFG_ADDR_DRIVE: next_rdata = {6'h00, drive};
      `ECGCFG_ADDR_R2: next_rdata = {4'h0, second_stage_decimation};
      `ECGCFG_ADDR_R3CH1: next_rdata = r3_rate[0];
      `ECGCFG_ADDR_R3CH2: next_rdata = r3_rate[1];
      `ECGCFG_ADDR_R3CH3: next_rdata = r3_rate[2];
      `ECGCFG_ADDR_PACE: next_rdata = {5'h00, pace_rate};
      `ECGCFG_ADDR_BYPASS: next_rdata = {5'h00, bypass};
      `ECGCFG_ADDR_DRSRC: next_rdata = {2'h0, dr_src};
      `ECGCFG_ADDR_SYNCCTL: next_rdata = {1'b0, sync_dir, sync_src};
      `ECGCFG_ADDR_DRMASK: next_rdata = {6'h00, dr_mask_ctl};
      `ECGCFG_ADDR_ALMASK: next_rdata = alarm_mask;
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data stands one cycle after the strobe
  always @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 8'h00;
  end

  // ------------------------------------------------------------
  // Data-ready masking interval
  // ------------------------------------------------------------
  wire any_ecg; // Some ECG channel running
  wire period_tick; // One output data period elapsed
  wire [3:0] mask_len; // Periods in this interval
  wire start_rise; // Start control turned on
  wire mask_trigger; // Begin a new interval
  wire [5:0] streams; // Pace and ECG ready pulses

  assign streams = {ecg_ready, pace_ready};
  assign any_ecg = |ecg_channel_en;
  // Lowest enabled ECG channel paces the count
  assign period_tick = any_ecg ?
    (ecg_channel_en[0] ? ecg_ready[0] :
     ecg_channel_en[1] ? ecg_ready[1] : ecg_ready[2]) :
    pace_ready[0];
  assign mask_len = (!any_ecg && pace_rate[0]) ?
    `ECGCFG_MASK_PERIODS_2X : `ECGCFG_MASK_PERIODS;
  assign start_rise = start_conversion_ctl && !start_d;
  assign mask_trigger =
    (start_rise && !dr_mask_ctl[`ECGCFG_DRMASK_START]) ||
    (out_of_sync_detect &&
     !dr_mask_ctl[`ECGCFG_DRMASK_RESYNC]);

  // Counts output periods; a new trigger restarts the count
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      start_d <= 1'b0;
      masking <= 1'b0;
      mask_count <= 4'h0;
    end
    else
    begin
      start_d <= start_conversion_ctl;
      if (mask_trigger)
      begin
        masking <= 1'b1;
        mask_count <= mask_len;
      end
      else if (masking && period_tick)
      begin
        // Last period ends the interval
        if (mask_count == 4'h1)
          masking <= 1'b0;
        mask_count <= mask_count - 4'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Data-ready and sync pins
  // ------------------------------------------------------------
  wire dr_event; // Selected stream pulsed
  wire sync_event; // Selected sync stream pulsed
  assign dr_event = |(streams & dr_src);
  assign sync_event = |(streams & sync_src);

  // Active low pulses on the pins
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      data_ready_n_pin <= 1'b1;
      sync_pin_o <= 1'b1;
      sync_in_d <= 1'b1;
      sync_pin_fall <= 1'b0;
    end
    else
    begin
      // Blocked while masking or with no source
      data_ready_n_pin <= !(dr_event && !masking
                            && !mask_trigger);
      sync_pin_o <= !sync_event;
      sync_in_d <= sync_in_s2;
      // Falling edge of an incoming sync, input mode only
      sync_pin_fall <= sync_dir && sync_in_d && !sync_in_s2;
    end
  end

  assign sync_pin_oe = !sync_dir;

  // ------------------------------------------------------------
  // Alarm pin
  // ------------------------------------------------------------
  wire ch3_err; // Any channel three range fault
  wire [7:0] alarm_cond; // Alarm conditions, mask order
  assign ch3_err = |{range3[6], range3[4:0]};
  assign alarm_cond = {raw_s2[14], ch3_err, raw_s2[15], raw_s2[16],
                       raw_s2[17], misc_err};

  // Masked conditions stay visible in status
  always @(posedge clk)
  begin
    if (!rst_n)
      alarm_n_pin <= 1'b1;
    else
      alarm_n_pin <= !(|(alarm_cond & ~alarm_mask));
  end

  assign alarm_status = !alarm_n_pin;

  // ------------------------------------------------------------
  // Configuration outputs
  // ------------------------------------------------------------
  assign drive_strength = drive;
  assign second_stage_rate = second_stage_decimation;
  assign third_stage_rate_ch1 = r3_rate[0];
  assign third_stage_rate_ch2 = r3_rate[1];
  assign third_stage_rate_ch3 = r3_rate[2];
  assign pace_rate_double = pace_rate;
  assign ecg_filter_bypass = bypass;

endmodule // ecgcfg_top

// ===== rtl/ecgcfg_regs.vh
// Offsets, field positions, reset values and counts of the status and
// rate configuration bank. Definitions only; included by the top module.
`ifndef ECGCFG_REGS_VH
`define ECGCFG_REGS_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define ECGCFG_ADDR_RANGE3 8'h1c
`define ECGCFG_ADDR_SYNCERR 8'h1d
`define ECGCFG_ADDR_MISCERR 8'h1e
`define ECGCFG_ADDR_DRIVE 8'h1f
`define ECGCFG_ADDR_R2 8'h21
`define ECGCFG_ADDR_R3CH1 8'h22
`define ECGCFG_ADDR_R3CH2 8'h23
`define ECGCFG_ADDR_R3CH3 8'h24
`define ECGCFG_ADDR_PACE 8'h25
`define ECGCFG_ADDR_BYPASS 8'h26
`define ECGCFG_ADDR_DRSRC 8'h27
`define ECGCFG_ADDR_SYNCCTL 8'h28
`define ECGCFG_ADDR_DRMASK 8'h29
`define ECGCFG_ADDR_ALMASK 8'h2a

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define ECGCFG_RST_DRIVE 2'h3
`define ECGCFG_RST_R2 4'h8
`define ECGCFG_RST_R3 8'h80
`define ECGCFG_RST_PACE 3'h0
`define ECGCFG_RST_BYPASS 3'h0
`define ECGCFG_RST_DRSRC 6'h00
`define ECGCFG_RST_SYNCSRC 6'h00
`define ECGCFG_RST_SYNCDIR 1'h1
`define ECGCFG_RST_DRMASK 2'h0
`define ECGCFG_RST_ALMASK 8'h00

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ECGCFG_SYNCCTL_DIR 6
`define ECGCFG_DRMASK_START 1
`define ECGCFG_DRMASK_RESYNC 0
`define ECGCFG_RANGE3_SIGN 5

// ------------------------------------------------------------
// Masking interval lengths in output data periods
// ------------------------------------------------------------
`define ECGCFG_MASK_PERIODS 4'h6
`define ECGCFG_MASK_PERIODS_2X 4'hb

`endif

// ===== bench/ecgcfg_assertions.sv
// Checker on the ports of the status and rate bank.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module ecgcfg_checker (
  input wire clk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire [1:0] drive_strength,
  input wire [3:0] second_stage_rate,
  input wire [7:0] third_stage_rate_ch1,
  input wire [7:0] third_stage_rate_ch3,
  input wire [2:0] pace_rate_double,
  input wire [2:0] pace_ready,
  input wire [2:0] ecg_ready,
  input wire data_ready_n_pin,
  input wire sync_pin_oe,
  input wire alarm_n_pin,
  input wire alarm_status
);
  // One domain, reset turns every check off
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_rdata_idle:
  assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_range3_resv:
  assert property ($past(reg_rd) && $past(reg_addr) == 8'h1c |-> !reg_rdata[7])
    else $error("range status top bit not zero");
  a_sync_resv:
  assert property ($past(reg_rd) && $past(reg_addr) == 8'h1d
    |-> reg_rdata[7:4] == 4'h0) else $error("sync status upper bits set");
  a_drive_rdback:
  assert property ($past(reg_rd) && $past(reg_addr) == 8'h1f
    |-> reg_rdata == {6'h00, $past(drive_strength)})
    else $error("drive readback differs from output");
  a_pace_rdback:
  assert property ($past(reg_rd) && $past(reg_addr) == 8'h25
    |-> reg_rdata == {5'h00, $past(pace_rate_double)})
    else $error("pace readback differs from output");
  a_r2_onehot:
  assert property ($onehot(second_stage_rate))
    else $error("second stage rate not one-hot");
  a_r3_onehot:
  assert property ($onehot(third_stage_rate_ch1) && $onehot(third_stage_rate_ch3))
    else $error("third stage rate not one-hot");
  a_alarm_status:
  assert property (alarm_status == !alarm_n_pin)
    else $error("alarm status disagrees with pin");
  a_drdy_pulse:
  assert property ($fell(data_ready_n_pin) |=> data_ready_n_pin)
    else $error("data ready low longer than a cycle");
  a_drdy_cause:
  assert property (!data_ready_n_pin |-> $past(|{pace_ready, ecg_ready}))
    else $error("data ready without a stream pulse");
  a_sync_dir:
  assert property ($past(reg_rd) && $past(reg_addr) == 8'h28
    |-> reg_rdata[6] == !$past(sync_pin_oe))
    else $error("sync direction bit disagrees with enable");
endmodule // ecgcfg_checker

bind ecgcfg_top ecgcfg_checker u_ecgcfg_checker (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .drive_strength(drive_strength),
  .second_stage_rate(second_stage_rate),
  .third_stage_rate_ch1(third_stage_rate_ch1),
  .third_stage_rate_ch3(third_stage_rate_ch3),
  .pace_rate_double(pace_rate_double), .pace_ready(pace_ready),
  .ecg_ready(ecg_ready), .data_ready_n_pin(data_ready_n_pin),
  .sync_pin_oe(sync_pin_oe), .alarm_n_pin(alarm_n_pin),
  .alarm_status(alarm_status)
);

// ===== bench/ecgcfg_far_model.sv
// Far side model: filter ready pulses and a host counting pin pulses.
// Assumes the sync pin level is resolved by the bench with a pull-up.
`timescale 1ns/10ps
module ecgcfg_far_model #(
  parameter PERIOD = 8
) (
  input wire clk,
  input wire rst_n,
  input wire data_ready_n_pin,
  input wire sync_pin,
  input wire sync_pin_oe,
  output logic [2:0] pace_ready,
  output logic [2:0] ecg_ready,
  output logic tick,
  output logic [7:0] drdy_cnt,
  output logic [7:0] sync_cnt
);
  logic [7:0] div; // Cycles since the last tick

  // All streams tick together; pin pulses are counted
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      div <= 8'h00;
      tick <= 1'b0;
      drdy_cnt <= 8'h00;
      sync_cnt <= 8'h00;
    end
    else
    begin
      div <= (div == PERIOD - 1) ? 8'h00 : div + 8'h01;
      tick <= (div == PERIOD - 1);
      if (!data_ready_n_pin)
        drdy_cnt <= drdy_cnt + 8'h01;
      if (sync_pin_oe && !sync_pin)
        sync_cnt <= sync_cnt + 8'h01;
    end
  end
  assign pace_ready = {3{tick}};
  assign ecg_ready = {3{tick}};
endmodule // ecgcfg_far_model

// ===== bench/ecg_afe_status_and_rate_config_tb_top.sv
// Self-checking bench for the status and rate bank.
// Assumes the checker is bound to the top module.
`timescale 1ns/10ps
module ecg_afe_status_and_rate_config_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic clk_digital_en = 1'b1;
  logic [6:0] r3 = 7'h00; // Range levels
  logic [3:0] sy = 4'h0; // Sync levels
  logic [2:0] mi = 3'h0; // Misc levels
  logic [7:0] al = 8'h00; // Alarm conditions, mask order
  logic [2:0] ecg_en = 3'h0;
  logic start = 1'b0;
  logic oos = 1'b0;
  logic [7:0] ra [0:12] = '{8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h21, 8'h22,
    8'h23, 8'h24, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h20};
  logic [7:0] rv [0:12] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h08, 8'h80,
    8'h80, 8'h80, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00};
  logic [7:0] wa [0:12] = '{8'h1f, 8'h21, 8'h21, 8'h21, 8'h22, 8'h23,
    8'h24, 8'h24, 8'h25, 8'h26, 8'h29, 8'h1c, 8'h20};
  logic [7:0] wd [0:12] = '{8'h02, 8'h03, 8'h00, 8'h04, 8'h01, 8'h00,
    8'hc0, 8'h20, 8'hff, 8'h05, 8'h03, 8'hff, 8'hff};
  logic [7:0] we [0:12] = '{8'h02, 8'h08, 8'h08, 8'h04, 8'h01, 8'h80,
    8'h80, 8'h20, 8'h07, 8'h05, 8'h03, 8'h00, 8'h00};
  integer fail_count = 0;
  integer compares = 0;
  integer cycles = 0;
  integer i;
  wire [7:0] reg_rdata;
  wire [1:0] drive_strength;
  wire [3:0] second_stage_rate;
  wire [7:0] third_stage_rate_ch1;
  wire [7:0] third_stage_rate_ch2;
  wire [7:0] third_stage_rate_ch3;
  wire [2:0] pace_rate_double;
  wire [2:0] ecg_filter_bypass;
  wire [2:0] pace_ready;
  wire [2:0] ecg_ready;
  wire data_ready_n_pin, sync_pin_o, sync_pin_oe, alarm_n_pin, alarm_status;
  wire tick;
  wire [7:0] drdy_cnt;
  wire [7:0] sync_cnt;
  wire sync_pin_fall;
  logic sync_ext = 1'b1; // Far device level, pull-up when idle
  wire sync_pin = sync_pin_oe ? sync_pin_o : sync_ext; // Released: far side

  ecgcfg_top u_ecgcfg_top (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .clk_digital_en(clk_digital_en), .modulator_overrange_ch3(r3[6]),
    .amp_output_a(r3[5]), .neg_out_near_low_rail_ch3(r3[4]),
    .neg_out_near_high_rail_ch3(r3[3]), .pos_out_near_low_rail_ch3(r3[2]),
    .pos_out_near_high_rail_ch3(r3[1]), .diff_out_range_ch3(r3[0] | al[6]),
    .timing_phase_adjusted(sy[3]), .filter_timing_resync_ch3(sy[2]),
    .filter_timing_resync_ch2(sy[1]), .filter_timing_resync_ch1(sy[0]),
    .low_supply_flag(mi[2] | al[2]), .leg_drive_near_rail_flag(mi[1] | al[1]),
    .common_level_out_of_range_flag(mi[0] | al[0]),
    .sync_edge_error(al[7]), .range_error_ch1(al[4]),
    .range_error_ch2(al[5]), .electrode_off(al[3]),
    .pace_ready(pace_ready), .ecg_ready(ecg_ready), .ecg_channel_en(ecg_en),
    .start_conversion_ctl(start), .out_of_sync_detect(oos),
    .drive_strength(drive_strength), .second_stage_rate(second_stage_rate),
    .third_stage_rate_ch1(third_stage_rate_ch1),
    .third_stage_rate_ch2(third_stage_rate_ch2),
    .third_stage_rate_ch3(third_stage_rate_ch3),
    .pace_rate_double(pace_rate_double),
    .ecg_filter_bypass(ecg_filter_bypass),
    .data_ready_n_pin(data_ready_n_pin), .sync_pin_o(sync_pin_o),
    .sync_pin_oe(sync_pin_oe), .sync_pin_i(sync_pin),
    .sync_pin_fall(sync_pin_fall),
    .alarm_n_pin(alarm_n_pin), .alarm_status(alarm_status)
  );

  ecgcfg_far_model u_ecgcfg_far_model (
    .clk(clk), .rst_n(rst_n), .data_ready_n_pin(data_ready_n_pin),
    .sync_pin(sync_pin), .sync_pin_oe(sync_pin_oe), .pace_ready(pace_ready),
    .ecg_ready(ecg_ready), .tick(tick), .drdy_cnt(drdy_cnt),
    .sync_cnt(sync_cnt)
  );

  // Clock and hang limit
  initial
    forever #20 clk = ~clk;
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      fail_count = fail_count + 1;
      close_out;
    end
  end

  task close_out;
    $display("mismatches %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    compares = compares + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // Register write, then an idle cycle
  task wr(input [7:0] a, input [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    cyc(1);
    reg_wr <= 1'b0;
    cyc(1);
  endtask
  // Register read, data taken in the cycle after the strobe
  task rc(input [7:0] a, input [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    cyc(1);
    reg_rd <= 1'b0;
    cyc(1);
    chk(reg_rdata, exp);
  endtask
  // Wait for a stream tick to land
  task align;
    do
      @(posedge clk);
    while (tick !== 1'b1);
  endtask
  // Count pin pulses over n ticks
  task win(input integer n, input [7:0] ed, input [7:0] es);
    logic [7:0] d0;
    logic [7:0] s0;
    cyc(2);
    d0 = drdy_cnt;
    s0 = sync_cnt;
    cyc(n * 8);
    chk(drdy_cnt - d0, ed);
    chk(sync_cnt - s0, es);
  endtask

  initial
  begin
    cyc(6);
    rst_n <= 1'b1;
    for (i = 0; i < 13; i = i + 1)
      rc(ra[i], rv[i]);
    for (i = 0; i < 13; i = i + 1)
    begin
      wr(wa[i], wd[i]);
      rc(wa[i], we[i]);
    end
    chk({6'h00, drive_strength}, 8'h02);
    chk({4'h0, second_stage_rate}, 8'h04);
    chk(third_stage_rate_ch3, 8'h20);
    chk({5'h00, pace_rate_double}, 8'h07);
    chk({5'h00, ecg_filter_bypass}, 8'h05);
    chk(third_stage_rate_ch1, 8'h01);
    chk(third_stage_rate_ch2, 8'h80);
    wr(8'h25, 8'h00);
    wr(8'h29, 8'h00);
    r3 <= 7'h7f;
    sy <= 4'hf;
    mi <= 3'h7;
    cyc(5);
    rc(8'h1c, 8'h7f);
    rc(8'h1d, 8'h0f);
    rc(8'h1e, 8'h07);
    clk_digital_en <= 1'b0;
    r3 <= 7'h00;
    sy <= 4'h0;
    mi <= 3'h0;
    cyc(5);
    rc(8'h1c, 8'h7f);
    clk_digital_en <= 1'b1;
    cyc(5);
    rc(8'h1c, 8'h00);
    for (i = 0; i < 8; i = i + 1)
    begin
      al <= 8'h01 << i;
      cyc(6);
      chk({7'h00, alarm_n_pin}, 8'h00);
      chk({7'h00, alarm_status}, 8'h01);
      wr(8'h2a, 8'h01 << i);
      cyc(6);
      chk({7'h00, alarm_n_pin}, 8'h01);
      if (i == 2)
        rc(8'h1e, 8'h04);
      wr(8'h2a, 8'h00);
      al <= 8'h00;
      cyc(6);
    end
    wr(8'h27, 8'h08);
    wr(8'h28, 8'h08);
    chk({7'h00, sync_pin_oe}, 8'h01);
    ecg_en <= 3'h1;
    align;
    start <= 1'b1;
    win(10, 8'h04, 8'h0a);
    start <= 1'b0;
    wr(8'h29, 8'h02);
    align;
    start <= 1'b1;
    win(10, 8'h0a, 8'h0a);
    wr(8'h29, 8'h00);
    align;
    oos <= 1'b1;
    cyc(1);
    oos <= 1'b0;
    win(10, 8'h04, 8'h0a);
    wr(8'h29, 8'h01);
    align;
    oos <= 1'b1;
    cyc(1);
    oos <= 1'b0;
    win(10, 8'h0a, 8'h0a);
    ecg_en <= 3'h0;
    wr(8'h25, 8'h01);
    wr(8'h27, 8'h01);
    wr(8'h29, 8'h00);
    start <= 1'b0;
    align;
    start <= 1'b1;
    win(16, 8'h05, 8'h10);
    wr(8'h28, 8'h40);
    chk({7'h00, sync_pin_oe}, 8'h00);
    win(4, 8'h04, 8'h00);
    // Far device pulls the released pin low: one edge pulse
    sync_ext <= 1'b0;
    cyc(4);
    chk({7'h00, sync_pin_fall}, 8'h01);
    cyc(1);
    chk({7'h00, sync_pin_fall}, 8'h00);
    sync_ext <= 1'b1;
    // Reset in mid-run restores defaults
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    rc(8'h1f, 8'h03);
    rc(8'h24, 8'h80);
    win(2, 8'h00, 8'h00);
    close_out;
  end
endmodule // ecg_afe_status_and_rate_config_tb_top
